// File: design/mrm_mac_rx_mgmt.sv
// Receive side of the media-independent interface, management master and
// the 48-byte register map of a 10/100 MAC.
// Assumes every pin input is asynchronous to clock and that the receive
// clock runs well below clock, so its edges are found by sampling.
//
// Behaviour
// - A receive nibble is taken at each rising receive clock edge with bit 0 as its low bit.
// - Nibbles are taken only while data-valid is high; the data lines are ignored otherwise.
// - A false carrier code with data-valid low is ignored and starts nothing.
// - Receive error while data-valid is high marks the frame as received with errors.
// - Receive error is looked at only while data-valid is high.
// - Carrier sense and collision are treated as asynchronous inputs.
// - In full duplex no behaviour depends on carrier sense or collision.
// - The management clock is driven out and never exceeds 2.5 MHz.
// - Management data is driven by the MAC and sampled back from the PHY on the management clock.
// - The register block spans 48 byte offsets from its base.
// - Both receive end pointers and the management read data are read-only.
// - The bus clock is at least as fast as the receive clock.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module mrm_mac_rx_mgmt
  import mrm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire mrm_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // Receive pins
  input wire logic mii_rxclk,
  input wire mrm_rx_pins_t mii_rx,
  input wire logic mii_crs,
  input wire logic mii_col,
  // Management pins
  output logic mii_mdc,
  input wire logic mii_mdio_i,
  output logic mii_mdio_o,
  output logic mii_mdio_oe,
  // Received byte stream
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  // Interrupt
  output logic irq
);

  mrm_state_t st_ff;
  mrm_state_t nxt_st;
  logic enable;
  logic fdx;
  logic rx_edge;
  logic col_rise;
  logic soft_rst;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;
  logic [15:0] cnt;
  logic [5:0] a;

  function automatic logic sw_writable(input logic [5:0] adr);
    logic ok;
    ok = (adr < MAP_BYTES[5:0]);
    case (adr)
      OFS_RSVD_A0, OFS_RSVD_A1, OFS_RSVD_B, OFS_RSVD_C: ok = 1'b0;
      OFS_MGMT_RDATA_HI, OFS_MGMT_RDATA_LO: ok = 1'b0;
      OFS_RX_A_PTR_HI, OFS_RX_A_PTR_LO: ok = 1'b0;
      OFS_RX_B_PTR_HI, OFS_RX_B_PTR_LO: ok = 1'b0;
      OFS_IRQ_EVENT_HI, OFS_IRQ_EVENT_LO, OFS_MGMT_CMD, OFS_SW_RESET: ok = 1'b0;
      default: ok = ok;
    endcase
    return ok;
  endfunction

  function automatic logic [7:0] reg_read(input mrm_state_t s, input logic [5:0] adr);
    logic [7:0] r;
    r = 8'h00;
    if (adr < MAP_BYTES[5:0]) begin
      r = s.regs[adr];
    end
    case (adr)
      OFS_RX_CTRL: begin
        r[RECEIVE_CONTROL_STATUS_ACTIVE_BIT] = (s.rx_state == RX_FRAME);
        r[RECEIVE_CONTROL_STATUS_CARRIER_BIT] = s.crs_s2 & ~s.regs[OFS_NET_CTRL][NETWORK_CONTROL_FDX_BIT];
      end
      OFS_IRQ_EVENT_HI: r = s.events[15:8];
      OFS_IRQ_EVENT_LO: r = s.events[7:0];
      OFS_MGMT_CMD: r[MCMD_BUSY_BIT] = (s.mg_state == MG_RUN);
      default: r = r;
    endcase
    return r;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    soft_rst = 1'b0;
    ev_set = 16'h0000;
    ev_clr = 16'h0000;
    cnt = st_ff.byte_cnt;
    a = bus_req.addr;
    enable = st_ff.regs[OFS_NET_CTRL][NETWORK_CONTROL_ENABLE_BIT];
    fdx = st_ff.regs[OFS_NET_CTRL][NETWORK_CONTROL_FDX_BIT];

    // Synchronisers; receive data shares the receive clock's delay
    nxt_st.rxclk_s1 = mii_rxclk;
    nxt_st.rxclk_s2 = st_ff.rxclk_s1;
    nxt_st.rxclk_s3 = st_ff.rxclk_s2;
    nxt_st.rx_s1 = mii_rx;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.crs_s1 = mii_crs;
    nxt_st.crs_s2 = st_ff.crs_s1;
    nxt_st.col_s1 = mii_col;
    nxt_st.col_s2 = st_ff.col_s1;
    nxt_st.col_s3 = st_ff.col_s2;
    nxt_st.mdio_s1 = mii_mdio_i;
    nxt_st.mdio_s2 = st_ff.mdio_s1;

    rx_edge = st_ff.rxclk_s2 & ~st_ff.rxclk_s3;
    col_rise = st_ff.col_s2 & ~st_ff.col_s3;

    // Receive nibble assembly, low nibble first
    nxt_st.rx_byte_valid = 1'b0;
    if (!enable) begin
      nxt_st.rx_state = RX_IDLE;
      nxt_st.nib_hi = 1'b0;
    end else if (rx_edge) begin
      case (st_ff.rx_state)
        RX_IDLE: begin
          // Data-valid low: error and any code, false carrier included, start nothing
          if (st_ff.rx_s2.dv) begin
            nxt_st.rx_state = RX_FRAME;
            nxt_st.nib_lo = st_ff.rx_s2.rxd;
            nxt_st.nib_hi = 1'b1;
            nxt_st.byte_cnt = 16'h0000;
            nxt_st.frame_err = st_ff.rx_s2.er;
          end
        end
        RX_FRAME: begin
          if (st_ff.rx_s2.dv) begin
            if (st_ff.rx_s2.er) begin
              nxt_st.frame_err = 1'b1;
            end
            if (st_ff.nib_hi) begin
              nxt_st.rx_byte = {st_ff.rx_s2.rxd, st_ff.nib_lo};
              nxt_st.rx_byte_valid = 1'b1;
              nxt_st.byte_cnt = st_ff.byte_cnt + 16'h0001;
              nxt_st.nib_hi = 1'b0;
            end else begin
              nxt_st.nib_lo = st_ff.rx_s2.rxd;
              nxt_st.nib_hi = 1'b1;
            end
          end else begin
            // Frame end: byte count goes to the pointer of the current bank
            if (st_ff.bank_b) begin
              nxt_st.regs[OFS_RX_B_PTR_HI] = cnt[15:8];
              nxt_st.regs[OFS_RX_B_PTR_LO] = cnt[7:0];
              ev_set[EV_RX_B] = 1'b1;
            end else begin
              nxt_st.regs[OFS_RX_A_PTR_HI] = cnt[15:8];
              nxt_st.regs[OFS_RX_A_PTR_LO] = cnt[7:0];
              ev_set[EV_RX_A] = 1'b1;
            end
            ev_set[EV_RX_ERR] = st_ff.frame_err | st_ff.nib_hi;
            nxt_st.bank_b = ~st_ff.bank_b;
            nxt_st.rx_state = RX_IDLE;
            nxt_st.nib_hi = 1'b0;
          end
        end
        default: nxt_st.rx_state = RX_IDLE;
      endcase
    end

    if (col_rise && enable && !fdx) begin
      ev_set[EV_COLLISION] = 1'b1;
    end

    // Management frame engine; data changes in the same cycle as each falling edge
    case (st_ff.mg_state)
      MG_IDLE: begin
        nxt_st.mdc = 1'b0;
        nxt_st.mdio_oe = 1'b0;
        nxt_st.phase = 8'h00;
      end
      MG_RUN: begin
        if (st_ff.phase == 8'(MDC_HALF_CYCLES - 1)) begin
          nxt_st.phase = 8'h00;
          nxt_st.mdc = ~st_ff.mdc;
          if (!st_ff.mdc) begin
            if (st_ff.op_read && st_ff.bit_idx >= MGMT_READ_DATA_FIRST) begin
              nxt_st.rd_shift = {st_ff.rd_shift[14:0], st_ff.mdio_s2};
            end
          end else if (st_ff.bit_idx == MGMT_LAST_BIT) begin
            nxt_st.mg_state = MG_IDLE;
            nxt_st.mdio_oe = 1'b0;
            nxt_st.mdio_o = 1'b0;
            ev_set[EV_MGMT_DONE] = 1'b1;
            if (st_ff.op_read) begin
              nxt_st.regs[OFS_MGMT_RDATA_HI] = st_ff.rd_shift[15:8];
              nxt_st.regs[OFS_MGMT_RDATA_LO] = st_ff.rd_shift[7:0];
            end
          end else begin
            nxt_st.bit_idx = st_ff.bit_idx + 6'h01;
            nxt_st.shift = {st_ff.shift[62:0], 1'b0};
            nxt_st.mdio_o = st_ff.shift[62];
            nxt_st.mdio_oe = ~st_ff.op_read || ((st_ff.bit_idx + 6'h01) < MGMT_READ_DRIVE_BITS);
          end
        end else begin
          nxt_st.phase = st_ff.phase + 8'h01;
        end
      end
      default: nxt_st.mg_state = MG_IDLE;
    endcase

    // Register writes
    if (bus_req.wr) begin
      if (a == OFS_SW_RESET) begin
        soft_rst = bus_req.wdata[SOFTWARE_RESET_BIT];
      end else if (a == OFS_IRQ_EVENT_HI) begin
        ev_clr = {bus_req.wdata, 8'h00};
      end else if (a == OFS_IRQ_EVENT_LO) begin
        ev_clr = {8'h00, bus_req.wdata};
      end else if (a == OFS_MGMT_CMD) begin
        nxt_st.regs[OFS_MGMT_CMD] = bus_req.wdata & 8'h3e;
        if (st_ff.mg_state == MG_IDLE &&
            (bus_req.wdata[MCMD_READ_BIT] || bus_req.wdata[MCMD_WRITE_BIT])) begin
          nxt_st.mg_state = MG_RUN;
          nxt_st.op_read = bus_req.wdata[MCMD_READ_BIT];
          nxt_st.bit_idx = 6'h00;
          nxt_st.phase = 8'h00;
          nxt_st.mdc = 1'b0;
          nxt_st.mdio_o = 1'b1;
          nxt_st.mdio_oe = 1'b1;
          nxt_st.rd_shift = 16'h0000;
          nxt_st.shift = {MGMT_PREAMBLE, MGMT_START,
                          bus_req.wdata[MCMD_READ_BIT] ? MGMT_OP_READ : MGMT_OP_WRITE,
                          st_ff.regs[OFS_MGMT_PHY][4:0], st_ff.regs[OFS_MGMT_REG][4:0],
                          bus_req.wdata[MCMD_READ_BIT] ? MGMT_TA_READ : MGMT_TA_WRITE,
                          st_ff.regs[OFS_MGMT_WDATA_HI], st_ff.regs[OFS_MGMT_WDATA_LO]};
        end
      end else if (sw_writable(a)) begin
        nxt_st.regs[a] = bus_req.wdata;
      end
    end

    // A new event wins over a clear in the same cycle
    nxt_st.events = (st_ff.events & ~ev_clr) | ev_set;
    nxt_st.irq = |(nxt_st.events & {nxt_st.regs[OFS_IRQ_MASK_HI], nxt_st.regs[OFS_IRQ_MASK_LO]});
    nxt_st.rd_data = bus_req.rd ? reg_read(st_ff, a) : 8'h00;

    if (soft_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd_data;
  assign mii_mdc = st_ff.mdc;
  assign mii_mdio_o = st_ff.mdio_o;
  assign mii_mdio_oe = st_ff.mdio_oe;
  assign rx_byte = st_ff.rx_byte;
  assign rx_byte_valid = st_ff.rx_byte_valid;
  assign irq = st_ff.irq;

endmodule

`default_nettype wire

// File: design/mrm_pkg.sv
// Package of the receive, management and register-map MAC slice.
// Assumes a 125 MHz system clock and a byte-wide register port.
package mrm_pkg;

  // Register map, byte offsets; 16-bit registers sit high byte first
  localparam logic [5:0] OFS_NET_CTRL = 6'h00;
  localparam logic [5:0] OFS_RSVD_A0 = 6'h01;
  localparam logic [5:0] OFS_RSVD_A1 = 6'h02;
  localparam logic [5:0] OFS_RX_CTRL = 6'h03;
  localparam logic [5:0] OFS_TX_CTRL = 6'h04;
  localparam logic [5:0] OFS_PROGRAMMABLE_ETHERTYPE_CTRL = 6'h05;
  localparam logic [5:0] OFS_PROGRAMMABLE_ETHERTYPE = 6'h06;
  localparam logic [5:0] OFS_PAUSE_TIME = 6'h08;
  localparam logic [5:0] OFS_IRQ_EVENT_HI = 6'h0a;
  localparam logic [5:0] OFS_IRQ_EVENT_LO = 6'h0b;
  localparam logic [5:0] OFS_IRQ_MASK_HI = 6'h0c;
  localparam logic [5:0] OFS_IRQ_MASK_LO = 6'h0d;
  localparam logic [5:0] OFS_SW_RESET = 6'h0e;
  localparam logic [5:0] OFS_RSVD_B = 6'h0f;
  localparam logic [5:0] OFS_MGMT_PHY = 6'h10;
  localparam logic [5:0] OFS_MGMT_REG = 6'h11;
  localparam logic [5:0] OFS_MGMT_WDATA_HI = 6'h12;
  localparam logic [5:0] OFS_MGMT_WDATA_LO = 6'h13;
  localparam logic [5:0] OFS_MGMT_RDATA_HI = 6'h14;
  localparam logic [5:0] OFS_MGMT_RDATA_LO = 6'h15;
  localparam logic [5:0] OFS_MGMT_CMD = 6'h16;
  localparam logic [5:0] OFS_RSVD_C = 6'h17;
  localparam logic [5:0] OFS_BUF_CFG = 6'h18;
  localparam logic [5:0] OFS_RX_A_PTR_HI = 6'h1a;
  localparam logic [5:0] OFS_RX_A_PTR_LO = 6'h1b;
  localparam logic [5:0] OFS_RX_B_PTR_HI = 6'h1c;
  localparam logic [5:0] OFS_RX_B_PTR_LO = 6'h1d;
  localparam logic [5:0] OFS_TX_PTR = 6'h1e;
  localparam logic [5:0] OFS_MCAST_HASH = 6'h20;
  localparam logic [5:0] OFS_STATION_ADDR = 6'h28;
  localparam logic [5:0] OFS_MISC = 6'h2e;
  localparam int unsigned MAP_BYTES = 48;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int unsigned NETWORK_CONTROL_ENABLE_BIT = 7;
  localparam int unsigned NETWORK_CONTROL_FDX_BIT = 0;
  localparam int unsigned RECEIVE_CONTROL_STATUS_ACTIVE_BIT = 7;
  localparam int unsigned RECEIVE_CONTROL_STATUS_CARRIER_BIT = 6;
  localparam int unsigned MCMD_READ_BIT = 7;
  localparam int unsigned MCMD_WRITE_BIT = 6;
  localparam int unsigned MCMD_BUSY_BIT = 0;
  localparam int unsigned SOFTWARE_RESET_BIT = 7;
  localparam int unsigned EV_MGMT_DONE = 0;
  localparam int unsigned EV_RX_A = 1;
  localparam int unsigned EV_RX_B = 2;
  localparam int unsigned EV_RX_ERR = 3;
  localparam int unsigned EV_COLLISION = 4;

  // Management clock timing
  localparam real CLK_MHZ = 125.0;
  localparam real MDC_MAX_MHZ = 2.5;
  localparam int MDC_HALF_CYCLES = int'($ceil(CLK_MHZ / (2.0 * MDC_MAX_MHZ)));

  // Management frame layout, bit index counted from the first preamble bit
  localparam logic [5:0] MGMT_LAST_BIT = 6'h3f;
  localparam logic [5:0] MGMT_READ_DRIVE_BITS = 6'h2e;
  localparam logic [5:0] MGMT_READ_DATA_FIRST = 6'h30;
  localparam logic [31:0] MGMT_PREAMBLE = 32'hffffffff;
  localparam logic [1:0] MGMT_START = 2'h1;
  localparam logic [1:0] MGMT_OP_READ = 2'h2;
  localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
  localparam logic [1:0] MGMT_TA_WRITE = 2'h2;
  localparam logic [1:0] MGMT_TA_READ = 2'h3;
  localparam logic [3:0] FALSE_CARRIER_CODE = 4'he;

  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_FRAME = 1'b1} mrm_rx_state_t;
  typedef enum logic [0:0] {MG_IDLE = 1'b0, MG_RUN = 1'b1} mrm_mg_state_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic dv;
    logic er;
  } mrm_rx_pins_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mrm_bus_req_t;

  typedef struct packed {
    logic [MAP_BYTES-1:0][7:0] regs;
    logic rxclk_s1;
    logic rxclk_s2;
    logic rxclk_s3;
    mrm_rx_pins_t rx_s1;
    mrm_rx_pins_t rx_s2;
    logic crs_s1;
    logic crs_s2;
    logic col_s1;
    logic col_s2;
    logic col_s3;
    logic mdio_s1;
    logic mdio_s2;
    mrm_rx_state_t rx_state;
    logic nib_hi;
    logic [3:0] nib_lo;
    logic [15:0] byte_cnt;
    logic frame_err;
    logic bank_b;
    logic [7:0] rx_byte;
    logic rx_byte_valid;
    logic [15:0] events;
    mrm_mg_state_t mg_state;
    logic op_read;
    logic mdc;
    logic [7:0] phase;
    logic [5:0] bit_idx;
    logic [63:0] shift;
    logic [15:0] rd_shift;
    logic mdio_o;
    logic mdio_oe;
    logic irq;
    logic [7:0] rd_data;
  } mrm_state_t;

endpackage

// File: verification/mrm_mac_monitor.sv
// Port checker of the MAC receive, management and register slice.
// Assumes it is bound into mrm_mac_rx_mgmt and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module mrm_mac_monitor
  import mrm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire mrm_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  // Receive pins
  input wire logic mii_rxclk,
  input wire mrm_rx_pins_t mii_rx,
  input wire logic mii_crs,
  input wire logic mii_col,
  // Management pins
  input wire logic mii_mdc,
  input wire logic mii_mdio_i,
  input wire logic mii_mdio_o,
  input wire logic mii_mdio_oe,
  // Stream and interrupt
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] mdc_run_ff;

  // Cycles since the management clock last moved
  always_ff @(posedge clock) begin
    if (reset || $changed(mii_mdc)) begin
      mdc_run_ff <= 8'h00;
    end else if (mdc_run_ff != 8'hff) begin
      mdc_run_ff <= mdc_run_ff + 8'h01;
    end
  end

  AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data outside a read cycle");
  AST_UNMAPPED: assert property ($past(bus_req.rd) && $past(bus_req.addr) >= 6'h30
    |-> rd_data == 8'h00) else $error("unmapped offset read not zero");
  AST_MDC_HALF: assert property ($changed(mii_mdc) |-> mdc_run_ff >= 8'h18)
    else $error("management clock phase too short");
  AST_MDIO_EDGE: assert property ($changed(mii_mdio_o) && $past(mii_mdio_oe) && mii_mdio_oe
    |-> $fell(mii_mdc)) else $error("management data moved off the falling clock");
  AST_OE_START: assert property ($rose(mii_mdio_oe) |-> !mii_mdc && mii_mdio_o)
    else $error("frame does not open with preamble one");
  AST_VALID_PULSE: assert property (rx_byte_valid |=> !rx_byte_valid [*8])
    else $error("byte strobe too long or too close");
  AST_VALID_DV: assert property (rx_byte_valid |-> $past(mii_rx.dv, 8))
    else $error("byte delivered without data valid");
  AST_BYTE_HOLD: assert property ($changed(rx_byte) |-> rx_byte_valid || $past(bus_req.wr))
    else $error("received byte changed without strobe");

  cover property (rx_byte_valid);
  cover property ($rose(mii_mdio_oe));
  cover property ($fell(irq));
endmodule

bind mrm_mac_rx_mgmt mrm_mac_monitor i_mon (.*);
`default_nettype wire

// File: verification/mrm_phy_model.sv
// PHY partner: receive nibbles and management slave with an MDIO pull-up.
// Assumes the bench clock; the receive clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none

module mrm_phy_model
  import mrm_pkg::*;
(
  // Bench clock
  input wire logic clock,
  // Receive pins
  output logic mii_rxclk,
  output var mrm_rx_pins_t mii_rx,
  // Management pins
  input wire logic mii_mdc,
  input wire logic mii_mdio_o,
  input wire logic mii_mdio_oe,
  output logic mii_mdio_i
);
  logic [63:0] cap = '0;
  logic [15:0] rd_val = '0;
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  logic rd_op = 1'b0;
  int n = 0;

  initial begin
    mii_rxclk = 1'b1;
    mii_rx = '0;
  end
  // Wire level: MAC, else PHY, else pull-up
  assign mii_mdio_i = mii_mdio_oe ? mii_mdio_o : (drv ? bit_q : 1'b1);

  // One nibble per 160 ns, changed just after a rising edge
  task automatic nib(input logic [3:0] d, input logic dv, input logic er);
    @(posedge clock);
    mii_rx <= '{rxd: d, dv: dv, er: er};
    repeat (9) @(posedge clock);
    mii_rxclk <= 1'b0;
    repeat (10) @(posedge clock);
    mii_rxclk <= 1'b1;
  endtask

  task automatic frame(input logic [7:0] b[$], input int er_at);
    nib(FALSE_CARRIER_CODE, 1'b0, 1'b1);
    foreach (b[i]) begin
      nib(b[i][3:0], 1'b1, i == er_at);
      nib(b[i][7:4], 1'b1, 1'b0);
    end
    nib(4'h0, 1'b0, 1'b0);
  endtask

  always @(posedge mii_mdio_oe) begin
    n = 0;
    rd_op = 1'b0;
  end
  always @(posedge mii_mdc) begin
    cap = {cap[62:0], mii_mdio_i};
    n = n + 1;
    if (n == 36) rd_op = (cap[1:0] == MGMT_OP_READ);
  end
  // Turnaround zero, then read data, after each falling edge
  always @(negedge mii_mdc) begin
    drv = rd_op && n >= 47 && n < 64;
    bit_q = (n == 47) ? 1'b0 : rd_val[63-n];
  end
endmodule
`default_nettype wire

// File: verification/mrm_mac_rx_mgmt_tb.sv
// Self-checking bench of the MAC slice against a register and stream model.
// Assumes the PHY partner model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

module mrm_mac_rx_mgmt_tb import mrm_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  mrm_bus_req_t bus_req = '0;
  logic mii_crs = 1'b0;
  logic mii_col = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] rx_byte;
  logic rx_byte_valid, irq, mii_rxclk, mii_mdc, mii_mdio_i, mii_mdio_o, mii_mdio_oe;
  mrm_rx_pins_t mii_rx;
  logic [7:0] m[64];
  logic [7:0] q[$];
  logic [4:0] ph, rg;
  logic [15:0] wd;
  int n_errors = 0;
  int n_checks = 0;

  always #4 clock = ~clock;
  mrm_mac_rx_mgmt i_dut (.*);
  mrm_phy_model i_phy (.*);

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkf(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] mgmt frame expected %h seen %h", e, g);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
    if (a == OFS_IRQ_EVENT_HI || a == OFS_IRQ_EVENT_LO) m[a] &= ~d;
    else if (a == OFS_SW_RESET) m = '{default: 8'h00};
    else if (!(a inside {6'h01, 6'h02, 6'h0f, [6'h14:6'h17], [6'h1a:6'h1d]}) && a < 6'h30) m[a] = d;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    @(negedge clock);
    chk("rd_data", e, rd_data);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(negedge clock);
    if (irq !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic send(input int len, input int er_at);
    logic [7:0] b[$];
    for (int i = 0; i < len; i++) b.push_back(8'($urandom));
    q = b;
    i_phy.frame(b, er_at);
  endtask
  task automatic col_pulse();
    @(posedge clock);
    mii_crs <= 1'b1;
    mii_col <= 1'b1;
    repeat (8) @(posedge clock);
    mii_col <= 1'b0;
    settle(6);
  endtask

  always @(negedge clock) begin
    if (rx_byte_valid === 1'b1 && q.size() == 0) chk("rx_byte count", 8'h00, 8'h01);
    else if (rx_byte_valid === 1'b1) chk("rx_byte", q.pop_front(), rx_byte);
  end

  initial begin
    m = '{default: 8'h00};
    void'($urandom(69546));
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 64; a++) rd(6'(a), REG_RESET);
    for (int a = 0; a < 64; a++) if (!(a inside {3, 14, 22})) wr(6'(a), 8'($urandom));
    for (int a = 0; a < 64; a++) rd(6'(a), m[a]);
    wr(OFS_SW_RESET, 8'h80);
    for (int a = 0; a < 48; a += 5) rd(6'(a), m[a]);
    wr(OFS_NET_CTRL, 8'h80);
    wr(OFS_IRQ_MASK_LO, 8'h0f);
    send(3, -1);
    settle(10);
    chk("irq", 8'h01, {7'h00, irq});
    rd(OFS_IRQ_EVENT_LO, 8'h02);
    rd(OFS_RX_A_PTR_LO, 8'h03);
    send(2, 1);
    settle(10);
    rd(OFS_IRQ_EVENT_LO, 8'h0e);
    rd(OFS_RX_B_PTR_LO, 8'h02);
    chk("rx_byte left", 8'h00, 8'(q.size()));
    wr(OFS_IRQ_EVENT_LO, 8'hff);
    settle(2);
    chk("irq", 8'h00, {7'h00, irq});
    col_pulse();
    rd(OFS_RX_CTRL, 8'h40);
    rd(OFS_IRQ_EVENT_LO, 8'h10);
    chk("irq", 8'h00, {7'h00, irq});
    wr(OFS_IRQ_EVENT_LO, 8'h10);
    wr(OFS_NET_CTRL, 8'h81);
    col_pulse();
    rd(OFS_IRQ_EVENT_LO, 8'h00);
    rd(OFS_RX_CTRL, 8'h00);
    @(posedge clock);
    mii_crs <= 1'b0;
    ph = 5'($urandom);
    rg = 5'($urandom);
    wd = 16'($urandom);
    wr(OFS_IRQ_MASK_LO, 8'h01);
    wr(OFS_MGMT_PHY, {3'h0, ph});
    wr(OFS_MGMT_REG, {3'h0, rg});
    wr(OFS_MGMT_WDATA_HI, wd[15:8]);
    wr(OFS_MGMT_WDATA_LO, wd[7:0]);
    wr(OFS_MGMT_CMD, 8'h40);
    rd(OFS_MGMT_CMD, 8'h01);
    wait_irq();
    chkf({MGMT_PREAMBLE, MGMT_START, MGMT_OP_WRITE, ph, rg, MGMT_TA_WRITE, wd}, i_phy.cap);
    wr(OFS_IRQ_EVENT_LO, 8'h01);
    i_phy.rd_val = 16'($urandom);
    wr(OFS_MGMT_CMD, 8'h80);
    settle(2);
    wait_irq();
    chkf({MGMT_PREAMBLE, MGMT_START, MGMT_OP_READ, ph, rg, 2'h2, i_phy.rd_val}, i_phy.cap);
    wr(OFS_MGMT_RDATA_HI, 8'hff);
    rd(OFS_MGMT_RDATA_HI, i_phy.rd_val[15:8]);
    rd(OFS_MGMT_RDATA_LO, i_phy.rd_val[7:0]);
    end_sim();
  end
endmodule
`default_nettype wire
